//--- kbs_pkg.sv
// Constants, carrier types and timing for the keyboard scan buffer and self-test
// Functional notes
// RULE1 - Pending scan codes wait in a seventeen-byte FIFO until output is allowed.
// RULE2 - Trying to place more than sixteen bytes in the FIFO is an overrun.
// RULE3 - On overrun the overrun marker takes the seventeenth position instead; the code puts it in the next free position (sixteenth if fifteen are stored).
// RULE4 - After overrun, further key data is dropped until output is next allowed.
// RULE5 - Command replies bypass the FIFO and never take a position in it.
// RULE6 - A multi-byte keystroke is stored whole or dropped whole with overrun.
// RULE7 - When output is allowed, stored bytes go first, then new key data.
// RULE8 - Every key event is turned into scan codes in arrival order.
// RULE9 - Every key but pause sends a press code and a release code.
// RULE10 - Held key repeats its press code after 500 ms, then 10.9 per second.
// RULE11 - Repeat delay and repeat rate are set by the system.
// RULE12 - Only the most recently pressed key repeats.
// RULE13 - Repeat stops when that last key is released, others still held.
// RULE14 - While inhibited, a held key stores only its first press code.
// RULE15 - Internal reset ends between 150 ms and 2.0 s after power arrives.
// RULE16 - Self-test checks core, ROM checksum and RAM; link lines are ignored.
// RULE17 - Indicator lamps are on for the whole self-test and off afterwards.
// RULE18 - Self-test lasts 300 ms to 500 ms after the power-up reset interval.
// RULE19 - Passing self-test sends AA, then scanning begins.
// RULE20 - Failing self-test sends FC and stays disabled until a command.
// RULE21 - Result goes out 450 ms to 2.5 s after power-up, 300-500 ms after reset.
// RULE22 - Right after power-up reset the link lines are sampled to pick the protocol.
// RULE23 - System holds both link lines high 500 us to accept a reset acknowledge.
// RULE24 - The overrun marker is a constant distinct from every valid scan code.
`default_nettype none
package kbs_pkg;
    // Buffer layout
    localparam int         FIFO_DEPTH   = 17;
    localparam logic [5:0] FIFO_LIMIT   = 6'h10;
    localparam logic [4:0] FIFO_FULL    = 5'h11;
    // Codes; zero never appears as a scan code, so it marks overrun
    localparam logic [7:0] OVERRUN_CODE = 8'h00;
    localparam logic [7:0] BREAK_PREFIX = 8'hF0;
    localparam logic [7:0] CODE_PASS    = 8'hAA;
    localparam logic [7:0] CODE_FAIL    = 8'hFC;
    localparam logic [7:0] RAM_PATTERN  = 8'h55;
    // Small fixed image checked by the self-test; contents are arbitrary
    localparam logic [7:0] ROM_IMAGE [4] = '{8'h12, 8'h34, 8'h56, 8'h78};
    localparam logic [7:0] ROM_SUM      = 8'h14;
    // Timing at the 25 MHz core clock
    localparam int         CLK_HZ             = 25_000_000;
    localparam int         CYC_PER_MS         = CLK_HZ / 1000;
    localparam int         POR_MIN_MS         = 150;
    localparam int         POR_DEF_CYC        = POR_MIN_MS * CYC_PER_MS;
    localparam int         TEST_MIN_MS        = 300;
    localparam int         TEST_DEF_CYC       = TEST_MIN_MS * CYC_PER_MS;
    localparam int         DELAY_UNIT_MS      = 250;
    localparam int         DELAY_UNIT_DEF_CYC = DELAY_UNIT_MS * CYC_PER_MS;
    localparam int         RATE_X10           = 109;
    localparam int         RATE_DEF_CYC       = CLK_HZ * 10 / RATE_X10;
    localparam logic [1:0] DELAY_SEL_DEF      = 2'h1;
    localparam logic [3:0] FRAME_BITS         = 4'h9;
    // Carriers
    typedef struct packed {
        logic       press;
        logic       pause;
        logic [7:0] code;
    } kbs_key_ev_s;
    typedef struct packed {
        logic clk_line;
        logic data_line;
    } kbs_lines_s;
    typedef enum logic [2:0] {M_POR, M_SENSE, M_TEST, M_REPORT, M_RUN, M_HALT} kbs_mode_e;
endpackage
`default_nettype wire

//--- kbs_top.sv
// Keyboard scan buffer, typematic repeat, power-on self-test and link byte sender
`timescale 1ns/1ps
`default_nettype none
module kbs_top #(
    parameter int POR_CYC        = kbs_pkg::POR_DEF_CYC,
    parameter int TEST_CYC       = kbs_pkg::TEST_DEF_CYC,
    parameter int DELAY_UNIT_CYC = kbs_pkg::DELAY_UNIT_DEF_CYC,
    parameter int RATE_CYC       = kbs_pkg::RATE_DEF_CYC
) (
    // Clocks and reset
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 link_clk,
    // Key events from the matrix scanner
    input  wire logic                 key_ev_valid,
    input  wire kbs_pkg::kbs_key_ev_s key_ev,
    // Command side
    input  wire logic                 reply_valid,
    input  wire logic [7:0]           reply_byte,
    input  wire logic                 cmd_reset,
    input  wire logic                 cmd_enable,
    input  wire logic [1:0]           dly_sel,
    input  wire logic [2:0]           rate_sel,
    input  wire logic                 core_fault,
    // Link pins
    input  wire kbs_pkg::kbs_lines_s  line_in,
    output logic                      link_data_out,
    output logic                      link_data_oe,
    // Status
    output logic                      lamps,
    output logic                      scanning,
    output logic                      overrun,
    output kbs_pkg::kbs_lines_s       proto
);
    import kbs_pkg::*;

    if (POR_CYC < 2 || TEST_CYC < 4 || DELAY_UNIT_CYC < 1 || RATE_CYC < 1) begin : g_bad
        $error("kbs_top: timing parameters too small");
    end

    kbs_mode_e   mode;
    logic [31:0] tmr;
    logic [7:0]  mem [FIFO_DEPTH];
    logic [4:0]  count;
    logic        ovr_lock;
    logic        ram_ok;
    logic        rom_ok;
    logic        reply_pend;
    logic [7:0]  reply_hold;
    logic [7:0]  tx_data;
    logic        tx_req;
    logic        ack_s1, ack_s2;
    kbs_lines_s  line_s1, line_s2;
    logic        inhibit_q;
    logic        rep_on;
    logic [7:0]  rep_key;
    logic [31:0] rep_cnt;
    logic        lk_ack;

    // Line levels cross in two stages before anything looks at them
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            line_s1 <= '0;
            line_s2 <= '0;
            ack_s1  <= 1'b0;
            ack_s2  <= 1'b0;
        end else begin
            line_s1 <= line_in;
            line_s2 <= line_s1;
            ack_s1  <= lk_ack;
            ack_s2  <= ack_s1;
        end
    end

    // Clock line held low by the system means output is inhibited
    logic inhibit;
    logic allow_rise;
    logic busy;
    logic ev_take;
    logic rep_fire;
    logic pop;
    assign inhibit    = ~line_s2.clk_line;
    assign allow_rise = inhibit_q & ~inhibit;
    assign busy       = tx_req != ack_s2;
    assign ev_take    = key_ev_valid & scanning; // [RULE8]
    assign rep_fire   = rep_on & (rep_cnt == 32'h0) & ~ev_take;
    // Replies win the sender; the FIFO drains only while output is allowed
    assign pop = scanning & ~busy & ~reply_pend & ~inhibit & (count != 5'h0); // [RULE5] [RULE7]

    always_ff @(posedge clock or posedge rst) begin
        if (rst) inhibit_q <= 1'b1;
        else     inhibit_q <= inhibit;
    end

    // Bytes wanted by this cycle's key event or repeat
    logic [1:0] want_n;
    logic [7:0] want_b0, want_b1;
    always_comb begin
        want_n  = 2'h0;
        want_b0 = key_ev.code;
        want_b1 = key_ev.code;
        if (ev_take) begin
            if (key_ev.press) begin
                want_n = 2'h1;
            end else if (!key_ev.pause) begin
                want_n  = 2'h2; // [RULE9]
                want_b0 = BREAK_PREFIX;
            end
        end else if (rep_fire && !inhibit) begin
            want_n  = 2'h1; // [RULE10] [RULE14]
            want_b0 = rep_key;
        end
    end

    // Whole keystroke or nothing; overflow leaves the marker instead
    logic [4:0] base;
    logic [1:0] push_n;
    logic [7:0] push_b0;
    logic       ovr_set;
    always_comb begin
        base    = count - {4'h0, pop};
        push_n  = 2'h0;
        push_b0 = want_b0;
        ovr_set = 1'b0;
        if (want_n != 2'h0 && !ovr_lock) begin
            if ({1'b0, base} + {4'h0, want_n} <= FIFO_LIMIT) begin
                push_n = want_n; // [RULE6]
            end else begin
                push_n  = (base < FIFO_FULL) ? 2'h1 : 2'h0; // [RULE2]
                push_b0 = OVERRUN_CODE; // [RULE3] [RULE24]
                ovr_set = 1'b1;
            end
        end
    end

    // Storage shifts toward the head on a pop; writes land after the last entry
    logic ram_wr;
    assign ram_wr = (mode == M_TEST) && (tmr == 32'h0);
    for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_mem
        logic [7:0] shifted;
        if (i == FIFO_DEPTH - 1) begin : g_last
            assign shifted = pop ? 8'h00 : mem[i];
        end else begin : g_mid
            assign shifted = pop ? mem[i+1] : mem[i];
        end
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                mem[i] <= 8'h00;
            end else if (ram_wr) begin
                mem[i] <= RAM_PATTERN; // [RULE16]
            end else if (push_n != 2'h0 && base == 5'(i)) begin
                mem[i] <= push_b0; // [RULE1]
            end else if (push_n == 2'h2 && base + 5'h1 == 5'(i)) begin
                mem[i] <= want_b1;
            end else begin
                mem[i] <= shifted;
            end
        end
    end

    // Occupancy; a new test or reset command empties the buffer
    always_ff @(posedge clock or posedge rst) begin
        if (rst)                  count <= 5'h0;
        else if (mode != M_RUN)   count <= 5'h0;
        else                      count <= base + {3'h0, push_n}; // [RULE1]
    end

    // Overrun lock: set wins over the clear when output is allowed again
    always_ff @(posedge clock or posedge rst) begin
        if (rst)                 ovr_lock <= 1'b0;
        else if (mode != M_RUN)  ovr_lock <= 1'b0;
        else if (ovr_set)        ovr_lock <= 1'b1; // [RULE2]
        else if (allow_rise)     ovr_lock <= 1'b0; // [RULE4]
    end

    // Typematic: last pressed key only, delay then steady rate
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rep_on  <= 1'b0;
            rep_key <= 8'h00;
            rep_cnt <= 32'h0;
        end else if (mode != M_RUN) begin
            rep_on  <= 1'b0;
        end else if (ev_take && key_ev.press && !key_ev.pause) begin
            rep_on  <= 1'b1; // [RULE12]
            rep_key <= key_ev.code;
            rep_cnt <= 32'(DELAY_UNIT_CYC * (int'(dly_sel) + 1) - 1); // [RULE10] [RULE11]
        end else if (ev_take && !key_ev.press && key_ev.code == rep_key) begin
            rep_on  <= 1'b0; // [RULE13]
        end else if (rep_fire) begin
            rep_cnt <= 32'(RATE_CYC * (int'(rate_sel) + 1) - 1); // [RULE11]
        end else if (rep_on && rep_cnt != 32'h0) begin
            rep_cnt <= rep_cnt - 32'h1;
        end
    end

    // Checksum over the fixed image
    function automatic logic [7:0] rom_total();
        logic [7:0] s;
        s = 8'h00;
        for (int k = 0; k < 4; k++) s = s + ROM_IMAGE[k];
        return s;
    endfunction

    // Power-on sequence, self-test and run/halt control
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode     <= M_POR;
            tmr      <= 32'h0;
            lamps    <= 1'b0;
            scanning <= 1'b0;
            proto    <= '0;
            ram_ok   <= 1'b0;
            rom_ok   <= 1'b0;
        end else begin
            unique case (mode)
                M_POR: begin
                    tmr <= tmr + 32'h1;
                    if (tmr == 32'(POR_CYC - 1)) mode <= M_SENSE; // [RULE15]
                end
                M_SENSE: begin
                    proto <= line_s2; // [RULE22]
                    tmr   <= 32'h0;
                    lamps <= 1'b1; // [RULE17]
                    mode  <= M_TEST;
                end
                M_TEST: begin
                    // Link lines and commands are ignored for the whole test
                    tmr <= tmr + 32'h1;
                    if (tmr == 32'h1) begin
                        ram_ok <= 1'b1;
                        for (int k = 0; k < FIFO_DEPTH; k++)
                            if (mem[k] != RAM_PATTERN) ram_ok <= 1'b0; // [RULE16]
                        rom_ok <= rom_total() == ROM_SUM;
                    end
                    if (tmr == 32'(TEST_CYC - 1)) begin
                        lamps <= 1'b0; // [RULE17] [RULE18]
                        mode  <= M_REPORT;
                    end
                end
                M_REPORT: begin
                    scanning <= ram_ok & rom_ok & ~core_fault; // [RULE19]
                    mode     <= (ram_ok & rom_ok & ~core_fault) ? M_RUN : M_HALT; // [RULE20]
                end
                M_RUN: begin
                    if (cmd_reset) begin
                        scanning <= 1'b0; // [RULE21]
                        lamps    <= 1'b1;
                        tmr      <= 32'h0;
                        mode     <= M_TEST;
                    end
                end
                M_HALT: begin
                    if (cmd_reset) begin
                        lamps <= 1'b1;
                        tmr   <= 32'h0;
                        mode  <= M_TEST;
                    end else if (cmd_enable) begin
                        scanning <= 1'b1; // [RULE20]
                        mode     <= M_RUN;
                    end
                end
            endcase
        end
    end

    // Single reply slot outside the FIFO; the result code outranks a reply
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reply_pend <= 1'b0;
            reply_hold <= 8'h00;
        end else if (mode == M_REPORT) begin
            reply_pend <= 1'b1;
            reply_hold <= (ram_ok & rom_ok & ~core_fault) ? CODE_PASS : CODE_FAIL; // [RULE19] [RULE20]
        end else if (reply_valid && mode != M_TEST) begin
            reply_pend <= 1'b1; // [RULE5]
            reply_hold <= reply_byte;
        end else if (reply_pend && !busy && !inhibit && mode != M_TEST) begin
            reply_pend <= 1'b0;
        end
    end

    // Byte handoff to the link domain by toggle request
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_req  <= 1'b0;
            tx_data <= 8'h00;
        end else if (reply_pend && !busy && !inhibit && mode != M_TEST) begin
            tx_req  <= ~tx_req;
            tx_data <= reply_hold;
        end else if (pop) begin
            tx_req  <= ~tx_req; // [RULE7]
            tx_data <= mem[0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) overrun <= 1'b0;
        else     overrun <= ovr_lock;
    end

    // Link domain: start bit then eight data bits, LSB first.
    // tx_data is stable until the ack returns, so it is read here unsynced.
    logic       lk_s1, lk_s2, lk_seen;
    logic [8:0] lk_shift;
    logic [3:0] lk_bits;
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            lk_s1         <= 1'b0;
            lk_s2         <= 1'b0;
            lk_seen       <= 1'b0;
            lk_shift      <= 9'h1FF;
            lk_bits       <= 4'h0;
            lk_ack        <= 1'b0;
            link_data_out <= 1'b1;
            link_data_oe  <= 1'b0;
        end else begin
            lk_s1 <= tx_req;
            lk_s2 <= lk_s1;
            if (lk_bits != 4'h0) begin
                link_data_out <= lk_shift[0];
                link_data_oe  <= 1'b1;
                lk_shift      <= {1'b1, lk_shift[8:1]};
                lk_bits       <= lk_bits - 4'h1;
                if (lk_bits == 4'h1) lk_ack <= lk_seen;
            end else begin
                link_data_out <= 1'b1;
                link_data_oe  <= 1'b0;
                if (lk_s2 != lk_seen) begin
                    lk_seen  <= lk_s2;
                    lk_shift <= {tx_data, 1'b0};
                    lk_bits  <= FRAME_BITS;
                end
            end
        end
    end

    // Checks in the core domain
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_fifo_bound: assert property (count <= FIFO_FULL) // [RULE1]
        else $error("fifo count above seventeen");
    a_ovr_set: assert property (ovr_set |=> ovr_lock && overrun == 1'b0 ##1 overrun) // [RULE2]
        else $error("overrun not flagged");
    a_ovr_marker: assert property (ovr_set && !pop && count < FIFO_FULL |=> mem[$past(count)] == OVERRUN_CODE) // [RULE3]
        else $error("overrun marker missing");
    a_drop_locked: assert property (ovr_lock && mode == M_RUN |=> count <= $past(count)) // [RULE4]
        else $error("data stored while overrun");
    a_reply_first: assert property (reply_pend && !busy && !inhibit && mode == M_RUN |=> tx_data == $past(reply_hold)) // [RULE5]
        else $error("fifo sent ahead of reply");
    a_whole_key: assert property (push_n == 2'h2 |-> base <= 5'hE) // [RULE6]
        else $error("split keystroke stored");
    a_hold_inhibit: assert property (inhibit |=> $stable(tx_req)) // [RULE7]
        else $error("byte launched while inhibited");
    a_pause_once: assert property (ev_take && key_ev.pause && !key_ev.press |-> want_n == 2'h0) // [RULE9]
        else $error("pause sent a release");
    a_repeat_hold: assert property (rep_fire && inhibit |-> want_n == 2'h0) // [RULE14]
        else $error("repeat stored while inhibited");
    a_lamps_test: assert property ($fell(lamps) |-> mode == M_REPORT && $past(tmr) == 32'(TEST_CYC - 1)) // [RULE17]
        else $error("lamps off at wrong time");
    a_por_length: assert property ($rose(mode == M_SENSE) |-> $past(tmr) == 32'(POR_CYC - 1)) // [RULE15]
        else $error("power-on reset too short");
endmodule
`default_nettype wire

//--- kbs_host.sv
// Host-side link partner: holds off the device and collects its frames
`timescale 1ns/1ps
`default_nettype none
module kbs_host (
    // Link clock and device drive
    input  wire logic                link_clk,
    input  wire logic                link_data_out,
    input  wire logic                link_data_oe,
    // Host control
    input  wire logic                inhibit,
    output var  kbs_pkg::kbs_lines_s line_in
);
    import kbs_pkg::*;
    logic [7:0] rx_q[$];
    logic [7:0] shift;
    int         frame_err;
    int         bit_n;
    // Clock line low means inhibit; data line has a pull-up when released
    assign line_in = '{clk_line: ~inhibit, data_line: (link_data_oe ? link_data_out : 1'b1)};
    // Sample mid-bit on the falling edge, away from the device's launch edge
    initial begin
        frame_err = 0;
        bit_n = 0;
        shift = 8'h00;
    end
    always @(negedge link_clk) begin
        if (link_data_oe === 1'b1) begin
            if (bit_n == 0 && link_data_out !== 1'b0) begin
                frame_err++;
            end else if (bit_n > 0) begin
                shift = {link_data_out, shift[7:1]};  // Data arrives low bit first
            end
            bit_n++;
            if (bit_n == 9) begin
                rx_q.push_back(shift);
                bit_n = 0;
            end
        end else begin
            bit_n = 0;
        end
    end
endmodule
`default_nettype wire

//--- tb_keyboard_scan_buffer_selftest.sv
// Self-checking bench: power-up, self-test, scan codes, repeat and overrun
`timescale 1ns/1ps
`default_nettype none
module tb_keyboard_scan_buffer_selftest;
    import kbs_pkg::*;
    // Shortened counts; repeat delay (dly_sel+1)*30, period (rate_sel+1)*10
    localparam int POR      = 20;
    localparam int TST      = 40;
    localparam int HOLD_CYC = 12500;
    localparam int LIMIT    = 40000;
    logic        clock, rst, link_clk, key_ev_valid, reply_valid, cmd_reset, cmd_enable;
    logic        core_fault, inhibit, link_data_out, link_data_oe, lamps, scanning, overrun;
    logic [7:0]  reply_byte;
    logic [1:0]  dly_sel;
    logic [2:0]  rate_sel;
    kbs_key_ev_s key_ev;
    kbs_lines_s  line_in, proto;
    int          fails, checks_done, rd_idx, cycles;

    kbs_top #(.POR_CYC(POR), .TEST_CYC(TST), .DELAY_UNIT_CYC(30), .RATE_CYC(10)) u_kbs_top (
        .clock(clock), .rst(rst), .link_clk(link_clk), .key_ev_valid(key_ev_valid), .key_ev(key_ev),
        .reply_valid(reply_valid), .reply_byte(reply_byte), .cmd_reset(cmd_reset),
        .cmd_enable(cmd_enable), .dly_sel(dly_sel), .rate_sel(rate_sel), .core_fault(core_fault),
        .line_in(line_in), .link_data_out(link_data_out), .link_data_oe(link_data_oe),
        .lamps(lamps), .scanning(scanning), .overrun(overrun), .proto(proto));
    kbs_host u_kbs_host (.link_clk(link_clk), .link_data_out(link_data_out),
        .link_data_oe(link_data_oe), .inhibit(inhibit), .line_in(line_in));

    // Core clock and an unrelated, slower link clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #80 link_clk = ~link_clk;
    end
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s: seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    // Inputs always move 1 ns after the rising edge
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
        tick();
    endtask
    task automatic key(input logic p, input logic ps, input logic [7:0] c);
        key_ev = '{press: p, pause: ps, code: c};
        key_ev_valid = 1'b1;
        tick();
        key_ev_valid = 1'b0;
        tick();
    endtask
    task automatic expect_byte(input logic [7:0] exp, input string msg);
        int n;
        n = 0;
        while (u_kbs_host.rx_q.size() <= rd_idx && n < 3000) begin
            tick();
            n++;
        end
        check(u_kbs_host.rx_q.size() > rd_idx ? u_kbs_host.rx_q[rd_idx] : 8'hXX, exp, msg);
        rd_idx++;
    endtask
    task automatic expect_quiet(input int n, input string msg);
        tick(n);
        check(8'(u_kbs_host.rx_q.size() - rd_idx), 8'h00, msg);
    endtask
    // Lamps window and result code; a reply offered mid-test must vanish
    task automatic selftest(input logic [7:0] code, input int lo, input int hi);
        int n;
        int h;
        n = 0;
        while (lamps !== 1'b1 && n < 500) begin
            tick();
            n++;
        end
        check({7'h0, n >= lo && n <= hi}, 8'h01, "lamps rise time");
        reply_byte = 8'h33;
        pulse(reply_valid);
        h = 2;
        while (lamps === 1'b1 && h < 500) begin
            tick();
            h++;
        end
        check({7'h0, h >= TST - 1 && h <= TST + 2}, 8'h01, "self-test length");
        expect_byte(code, "result code");
        expect_quiet(100, "nothing after result");
    endtask
    task automatic power_up();
        selftest(CODE_PASS, POR, POR + 3);
        check({6'h0, proto}, 8'h03, "line levels sensed");
        check({7'h0, scanning}, 8'h01, "scanning after pass");
    endtask
    task automatic make_break();
        key(1'b1, 1'b0, 8'h1C);
        key(1'b0, 1'b0, 8'h1C);
        key(1'b1, 1'b1, 8'h77);
        key(1'b0, 1'b1, 8'h77);
        expect_byte(8'h1C, "make code");
        expect_byte(BREAK_PREFIX, "break prefix");
        expect_byte(8'h1C, "break code");
        expect_byte(8'h77, "pause make");
        expect_quiet(300, "pause gives no break or repeat");
    endtask
    // Delay 120, period 80: the later key repeats twice, the earlier never
    task automatic typematic();
        logic [7:0] seq [8] = '{8'h1C, 8'h32, 8'h32, 8'h32, 8'hF0, 8'h32, 8'hF0, 8'h1C};
        dly_sel = 2'h3;
        rate_sel = 3'h7;
        key(1'b1, 1'b0, 8'h1C);
        key(1'b1, 1'b0, 8'h32);
        tick(246);
        key(1'b0, 1'b0, 8'h32);
        tick(300);
        key(1'b0, 1'b0, 8'h1C);
        foreach (seq[i]) expect_byte(seq[i], "typematic stream");
        expect_quiet(300, "repeat ended");
    endtask
    task automatic inhibit_hold();
        inhibit = 1'b1;
        tick(4);
        key(1'b1, 1'b0, 8'h2A);
        tick(400);
        key(1'b0, 1'b0, 8'h2A);
        inhibit = 1'b0;
        expect_byte(8'h2A, "single make while held off");
        expect_byte(BREAK_PREFIX, "break prefix");
        expect_byte(8'h2A, "break code");
        expect_quiet(300, "no stored repeats");
    endtask
    // n stored codes, then a keystroke that does not fit and one more
    task automatic overrun_case(input int n);
        inhibit = 1'b1;
        tick(4);
        reply_byte = 8'hFA;
        pulse(reply_valid);
        for (int i = 0; i < n; i++) key(1'b1, 1'b1, 8'h40 + 8'(i));
        if (n == 16) key(1'b1, 1'b1, 8'h60);
        else key(1'b0, 1'b0, 8'h61);
        key(1'b1, 1'b1, 8'h62);
        tick(2);
        check({7'h0, overrun}, 8'h01, "overrun flagged");
        inhibit = 1'b0;
        tick(150);
        key(1'b1, 1'b1, 8'h63);
        expect_byte(8'hFA, "reply bypasses store");
        for (int i = 0; i < n; i++) expect_byte(8'h40 + 8'(i), "stored code");
        expect_byte(OVERRUN_CODE, "overrun marker");
        expect_byte(8'h63, "new data after store");
        expect_quiet(200, "dropped data stays lost");
        check({7'h0, overrun}, 8'h00, "overrun cleared");
    endtask
    task automatic fail_reset();
        core_fault = 1'b1;
        tick(HOLD_CYC);  // both lines high to accept the acknowledge
        pulse(cmd_reset);
        selftest(CODE_FAIL, 0, POR + 3);
        core_fault = 1'b0;
        check({7'h0, scanning}, 8'h00, "halted after fail");
        key(1'b1, 1'b1, 8'h1C);
        expect_quiet(200, "halted keyboard sends nothing");
        pulse(cmd_enable);
        check({7'h0, scanning}, 8'h01, "command restarts scanning");
    endtask

    initial begin
        fails = 0;
        checks_done = 0;
        rd_idx = 0;
        cycles = 0;
        rst = 1'b1;
        key_ev_valid = 1'b0;
        key_ev = '0;
        reply_valid = 1'b0;
        reply_byte = 8'h00;
        cmd_reset = 1'b0;
        cmd_enable = 1'b0;
        dly_sel = DELAY_SEL_DEF;
        rate_sel = 3'h0;
        core_fault = 1'b0;
        inhibit = 1'b0;
        tick(10);
        rst = 1'b0;
        power_up();
        make_break();
        typematic();
        inhibit_hold();
        overrun_case(16);
        overrun_case(15);
        fail_reset();
        check(8'(u_kbs_host.frame_err), 8'h00, "start bits low");
        end_of_test();
    end
endmodule
`default_nettype wire
